/* File: design/gain_select.v */
`timescale 1ns/1ps
`include "txch_defines.vh"
module gain_select (
	input wire sel_in,
	input wire reg_dig_in,
	input wire [3:0] reg_buf_in,
	input wire agc_dig_in,
	input wire [3:0] agc_buf_in,
	output wire dig_out,
	output wire [3:0] buf_out
);
	assign dig_out = sel_in ? reg_dig_in : agc_dig_in;
	assign buf_out = sel_in ? reg_buf_in : agc_buf_in;
endmodule // gain_select

/* File: design/tx_channel_scan_gain_regs.v */
`timescale 1ns/1ps
`include "txch_defines.vh"
module tx_channel_scan_gain_regs (
	input wire sys_clk_in,
	input wire reset_in,
	input wire clk_en_in,
	input wire [3:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0] avs_byteenable_in,
	output reg [31:0] avs_readdata_out,
	output wire avs_waitrequest_out,
	input wire scan_valid_in,
	input wire [9:0] scan_channel_in,
	input wire agc_dig_gain_in,
	input wire [3:0] agc_buf_gain_in,
	output reg [9:0] tx_channel_index_out,
	output reg [16:0] carrier_khz_out,
	output reg [9:0] scan_start_index_out,
	output reg [9:0] scan_stop_index_out,
	output reg [16:0] scan_start_khz_out,
	output reg [16:0] scan_stop_khz_out,
	output reg [7:0] scan_step_khz_out,
	output reg step_reserved_out,
	output reg [7:0] amp_target_out,
	output reg [15:0] amp_target_centi_dbuv_out,
	output reg amp_target_invalid_out,
	output reg softclip_en_out,
	output reg gain_sel_out,
	output wire dig_gain_out,
	output wire [3:0] buf_gain_out
);
	reg [7:0] chan_low_q;
	reg [7:0] start_low_q;
	reg [7:0] stop_low_q;
	reg [7:0] step_q;
	reg [7:0] amp_q;
	reg [7:0] gain_q;
	reg [7:0] ctrl_q;
	reg [9:0] scan_chan_q;
	reg ack_q;
	reg [31:0] rdata_d;
	wire req;
	wire wr_low;
	wire [9:0] user_chan;
	wire [9:0] eff_chan;
	wire [9:0] start_idx;
	wire [9:0] stop_idx;
	wire [15:0] amp_centi;

	// one wait cycle per access; answer comes the cycle after the request
	assign req = (avs_read_in | avs_write_in) & clk_en_in;
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
	assign wr_low = avs_write_in & ack_q & avs_byteenable_in[0];

	assign user_chan = {step_q[`BIT_CHAN_HI], chan_low_q};
	assign eff_chan = ctrl_q[`BIT_SCAN_DIS] ? user_chan : scan_chan_q;
	assign start_idx = {step_q[`BIT_START_HI], start_low_q};
	assign stop_idx = {step_q[`BIT_STOP_HI], stop_low_q};
	assign amp_centi = `PA_BASE_CENTI + `PA_SLOPE_CENTI * {8'h00, amp_q};

	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			ack_q <= 1'b0;
		end else if (clk_en_in) begin
			ack_q <= req & ~ack_q;
		end
	end

	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			chan_low_q <= `RST_CHANNEL_LOW;
			start_low_q <= `RST_START_LOW;
			stop_low_q <= `RST_STOP_LOW;
			step_q <= `RST_STEP_HIGH;
			amp_q <= `RST_AMP_TARGET;
			gain_q <= `RST_AUDIO_GAIN;
			ctrl_q <= `RST_CONTROL;
			// scan copy starts on the same channel the user copy resets to
			scan_chan_q <= {2'b00, `RST_CHANNEL_LOW};
		end else if (clk_en_in) begin
			// scan result is captured in its own register, apart from the user copy
			if (scan_valid_in) begin
				scan_chan_q <= scan_channel_in;
			end
			if (wr_low) begin
				case (avs_address_in)
				`OFS_CHANNEL_LOW: chan_low_q <= avs_writedata_in[7:0];
				`OFS_START_LOW: start_low_q <= avs_writedata_in[7:0];
				`OFS_STOP_LOW: stop_low_q <= avs_writedata_in[7:0];
				`OFS_STEP_HIGH: step_q <= avs_writedata_in[7:0];
				`OFS_AMP_TARGET: amp_q <= avs_writedata_in[7:0];
				`OFS_AUDIO_GAIN: gain_q <= {avs_writedata_in[7:6], 1'b0, avs_writedata_in[4:0]};
				`OFS_CONTROL: ctrl_q <= {7'h00, avs_writedata_in[`BIT_SCAN_DIS]};
				default: ctrl_q <= ctrl_q;
				endcase
			end
		end
	end

	// write-only fields read back as zero
	always @* begin
		rdata_d = 32'h00000000;
		case (avs_address_in)
		`OFS_CHANNEL_LOW: rdata_d = {24'h000000, eff_chan[7:0]};
		`OFS_STEP_HIGH: rdata_d = {30'h00000000, eff_chan[9:8]};
		`OFS_AUDIO_GAIN: rdata_d = {26'h0000000, 1'b0, gain_q[4:0]};
		`OFS_CONTROL: rdata_d = {24'h000000, ctrl_q};
		default: rdata_d = 32'h00000000;
		endcase
	end

	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			avs_readdata_out <= 32'h00000000;
		end else if (clk_en_in & avs_read_in & ~ack_q) begin
			avs_readdata_out <= rdata_d;
		end
	end

	always @(posedge sys_clk_in) begin
		if (reset_in) begin
			tx_channel_index_out <= 10'h000;
			carrier_khz_out <= 17'h00000;
			scan_start_index_out <= 10'h000;
			scan_stop_index_out <= 10'h000;
			scan_start_khz_out <= 17'h00000;
			scan_stop_khz_out <= 17'h00000;
			scan_step_khz_out <= 8'h00;
			step_reserved_out <= 1'b0;
			amp_target_out <= 8'h00;
			amp_target_centi_dbuv_out <= 16'h0000;
			amp_target_invalid_out <= 1'b0;
			softclip_en_out <= 1'b0;
			gain_sel_out <= 1'b0;
		end else if (clk_en_in) begin
			tx_channel_index_out <= eff_chan;
			carrier_khz_out <= `BASE_KHZ + `CHAN_KHZ * {7'h00, eff_chan};
			scan_start_index_out <= start_idx;
			scan_stop_index_out <= stop_idx;
			scan_start_khz_out <= `BASE_KHZ + `CHAN_KHZ * {7'h00, start_idx};
			scan_stop_khz_out <= `BASE_KHZ + `CHAN_KHZ * {7'h00, stop_idx};
			case (step_q[`BIT_STEP])
			`STEP_50: scan_step_khz_out <= 8'h32;
			`STEP_100: scan_step_khz_out <= 8'h64;
			`STEP_200: scan_step_khz_out <= 8'hc8;
			default: scan_step_khz_out <= 8'h00;
			endcase
			// reserved spacing is flagged, never silently stepped
			step_reserved_out <= (step_q[`BIT_STEP] == 2'b11);
			amp_target_out <= amp_q;
			amp_target_centi_dbuv_out <= amp_centi;
			amp_target_invalid_out <= (amp_centi < `PA_MIN_CENTI) | (amp_centi > `PA_MAX_CENTI);
			softclip_en_out <= gain_q[`BIT_SOFTCLIP];
			gain_sel_out <= gain_q[`BIT_GAIN_SEL];
		end
	end

	gain_select u_gain_select (
		.sel_in(gain_q[`BIT_GAIN_SEL]),
		.reg_dig_in(gain_q[`BIT_DIG_GAIN]),
		.reg_buf_in(gain_q[`BIT_BUF_GAIN]),
		.agc_dig_in(agc_dig_gain_in),
		.agc_buf_in(agc_buf_gain_in),
		.dig_out(dig_gain_out),
		.buf_out(buf_gain_out)
	);
endmodule // tx_channel_scan_gain_regs

/* File: design/txch_defines.vh */
// Functional notes
// - The transmit channel index is ten bits: low byte from the channel register, top two bits from step register bits 1:0.
// - A scan-selected channel lives in its own register and is read back and used for transmission while scan_channel_disable is 0.
// - The carrier is 76 MHz plus the channel index times 0.05 MHz.
// - The scan start index is a write-only low byte plus step register bits 3:2, at 76 MHz plus index times 0.05 MHz.
// - The scan stop index is a write-only low byte plus step register bits 5:4, at 76 MHz plus index times 0.05 MHz.
// - Scan spacing from step bits 7:6 is 50, 100 or 200 kHz; code 11 is reserved.
// - Amplifier target is 0.37 times the code plus 68 dBuV, valid from 31 to 131 dBuV.
`ifndef TXCH_DEFINES_VH
`define TXCH_DEFINES_VH
`define OFS_CHANNEL_LOW 4'h8
`define OFS_START_LOW 4'h9
`define OFS_STOP_LOW 4'ha
`define OFS_STEP_HIGH 4'hb
`define OFS_AMP_TARGET 4'hc
`define OFS_AUDIO_GAIN 4'hd
`define OFS_CONTROL 4'h0
`define RST_CHANNEL_LOW 8'ha0
`define RST_START_LOW 8'h00
`define RST_STOP_LOW 8'h80
`define RST_STEP_HIGH 8'h60
`define RST_AMP_TARGET 8'hff
`define RST_AUDIO_GAIN 8'h01
`define RST_CONTROL 8'h00
`define BIT_CHAN_HI 1:0
`define BIT_START_HI 3:2
`define BIT_STOP_HI 5:4
`define BIT_STEP 7:6
`define BIT_SOFTCLIP 7
`define BIT_GAIN_SEL 6
`define BIT_DIG_GAIN 4
`define BIT_BUF_GAIN 3:0
`define BIT_SCAN_DIS 0
`define BASE_KHZ 17'd76000
`define CHAN_KHZ 17'd50
`define STEP_50 2'b00
`define STEP_100 2'b01
`define STEP_200 2'b10
`define PA_BASE_CENTI 16'd6800
`define PA_SLOPE_CENTI 16'd37
`define PA_MIN_CENTI 16'd3100
`define PA_MAX_CENTI 16'd13100
`endif

/* File: test/tx_channel_scan_gain_regs_tb.sv */
`timescale 1ns/1ps
module tx_channel_scan_gain_regs_tb;
	logic sys_clk_in = 0, reset_in = 1, clk_en_in = 1, avs_read_in = 0, avs_write_in = 0, scan_valid_in = 0;
	logic agc_dig_gain_in = 1, avs_waitrequest_out, step_reserved_out, amp_target_invalid_out;
	logic softclip_en_out, gain_sel_out, dig_gain_out;
	logic [3:0] avs_address_in = 0, avs_byteenable_in = 4'hf, agc_buf_gain_in = 4'h5, buf_gain_out;
	logic [31:0] avs_writedata_in = 0, avs_readdata_out;
	logic [9:0] scan_channel_in = 0, tx_channel_index_out, scan_start_index_out, scan_stop_index_out;
	logic [16:0] carrier_khz_out, scan_start_khz_out, scan_stop_khz_out;
	logic [7:0] scan_step_khz_out, amp_target_out, stk[4] = '{8'd50, 8'd100, 8'd200, 8'd0};
	logic [15:0] amp_target_centi_dbuv_out;
	int n_mismatch = 0, checks_done = 0, cen;
	tx_channel_scan_gain_regs dut (.*);
	always #2 sys_clk_in = ~sys_clk_in;
	task chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// ends on a falling edge so registered outputs have settled
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		avs_address_in <= a; avs_writedata_in <= {24'h0, d}; avs_write_in <= w; avs_read_in <= !w;
		do @(negedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
		@(posedge sys_clk_in);
		avs_write_in <= 0; avs_read_in <= 0;
		@(posedge sys_clk_in);
		@(negedge sys_clk_in);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d); bus(1, a, d); endtask
	task rd(input logic [3:0] a, input logic [7:0] e); bus(0, a, 0); chk("readdata", e, avs_readdata_out); endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge sys_clk_in);
		n_mismatch++;
		$display("[FAIL] watchdog expected done seen timeout");
		test_done;
	end
	initial begin
		repeat (16) @(posedge sys_clk_in);
		reset_in <= 0;
		rd(4'h8, 8'ha0); rd(4'hb, 8'h00);
		rd(4'h9, 8'h00); rd(4'h3, 8'h00); rd(4'hd, 8'h01);
		chk("carrier", 84000, carrier_khz_out);
		chk("stop", 10'h280, scan_stop_index_out); chk("stop_khz", 108000, scan_stop_khz_out);
		chk("step", 100, scan_step_khz_out); chk("amp", 16235, amp_target_centi_dbuv_out);
		chk("buf", 5, buf_gain_out); chk("dig", 1, dig_gain_out);
		$display("test reset done");
		@(posedge sys_clk_in);
		scan_channel_in <= 10'h3ff; scan_valid_in <= 1;
		@(posedge sys_clk_in);
		scan_valid_in <= 0;
		rd(4'h8, 8'hff); rd(4'hb, 8'h03); chk("carrier", 127150, carrier_khz_out);
		$display("test scan done");
		wr(4'h0, 8'h01); wr(4'h8, 8'h55); wr(4'h9, 8'h12); wr(4'ha, 8'h34); wr(4'hb, 8'h9e);
		chk("index", 10'h255, tx_channel_index_out); rd(4'h8, 8'h55); rd(4'ha, 8'h00);
		chk("start", 115300, scan_start_khz_out); chk("stop", 91400, scan_stop_khz_out);
		chk("start_idx", 10'h312, scan_start_index_out);
		for (int c = 0; c < 4; c++) begin
			wr(4'hb, {c[1:0], 6'h1e});
			chk("step", stk[c], scan_step_khz_out); chk("rsv", c == 3, step_reserved_out);
		end
		$display("test channel done");
		for (int c = 169; c < 172; c++) begin
			wr(4'hc, c[7:0]);
			cen = 6800 + 37 * c;
			chk("amp_code", c, amp_target_out);
			chk("inv", cen < 3100 || cen > 13100, amp_target_invalid_out);
		end
		$display("test amp done");
		@(posedge sys_clk_in);
		avs_byteenable_in <= 4'h0;
		wr(4'h8, 8'h11);
		avs_byteenable_in <= 4'hf;
		chk("be_off", 10'h255, tx_channel_index_out);
		wr(4'hd, 8'hc3);
		chk("dig", 0, dig_gain_out); chk("buf", 3, buf_gain_out); rd(4'hd, 8'h03);
		chk("clip", 1, softclip_en_out); chk("sel", 1, gain_sel_out);
		$display("test gain done");
		@(posedge sys_clk_in);
		clk_en_in <= 0; scan_channel_in <= 10'h001; scan_valid_in <= 1;
		@(posedge sys_clk_in);
		scan_valid_in <= 0; clk_en_in <= 1;
		wr(4'h0, 8'h00); rd(4'h8, 8'hff); rd(4'hb, 8'h03);
		$display("test freeze done");
		test_done;
	end
endmodule // tx_channel_scan_gain_regs_tb

/* File: test/txch_monitor.sv */
`timescale 1ns/1ps
module txch_monitor (
	input wire sys_clk_in,
	input wire reset_in,
	input wire clk_en_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire avs_waitrequest_out,
	input wire step_reserved_out,
	input wire amp_target_invalid_out,
	input wire gain_sel_out,
	input wire dig_gain_out,
	input wire agc_dig_gain_in,
	input wire [3:0] avs_address_in,
	input wire [3:0] buf_gain_out,
	input wire [3:0] agc_buf_gain_in,
	input wire [31:0] avs_readdata_out,
	input wire [9:0] tx_channel_index_out,
	input wire [9:0] scan_start_index_out,
	input wire [9:0] scan_stop_index_out,
	input wire [16:0] carrier_khz_out,
	input wire [16:0] scan_start_khz_out,
	input wire [16:0] scan_stop_khz_out,
	input wire [7:0] scan_step_khz_out,
	input wire [7:0] amp_target_out,
	input wire [15:0] amp_target_centi_dbuv_out
);
	// registered outputs read 0 until the first edge after reset
	reg [1:0] up_q;
	always @(posedge sys_clk_in) up_q <= reset_in ? 2'b00 : {up_q[0], 1'b1};
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in || !up_q[1]);
	wire rd_ok = avs_read_in && !avs_waitrequest_out;
	a_carrier_map: assert property (carrier_khz_out == 17'd76000 + 17'd50 * tx_channel_index_out) else $error("carrier");
	a_start_map: assert property (scan_start_khz_out == 17'd76000 + 17'd50 * scan_start_index_out) else $error("start");
	a_stop_map: assert property (scan_stop_khz_out == 17'd76000 + 17'd50 * scan_stop_index_out) else $error("stop");
	a_step_set: assert property (step_reserved_out ? scan_step_khz_out == 8'h00 :
		scan_step_khz_out inside {8'd50, 8'd100, 8'd200}) else $error("step");
	a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out && clk_en_in
		|=> !avs_waitrequest_out) else $error("wait");
	a_amp_scale: assert property (amp_target_centi_dbuv_out == 16'd6800 + 16'd37 * amp_target_out) else $error("amp");
	a_amp_range: assert property (amp_target_invalid_out ==
		(amp_target_centi_dbuv_out < 16'd3100 || amp_target_centi_dbuv_out > 16'd13100)) else $error("range");
	a_gain_agc: assert property (!gain_sel_out ##1 !gain_sel_out |->
		$past(dig_gain_out) == $past(agc_dig_gain_in) && $past(buf_gain_out) == $past(agc_buf_gain_in)) else $error("gain");
	a_chan_low: assert property (rd_ok && avs_address_in == 4'h8 |=> avs_readdata_out == {24'h0, tx_channel_index_out[7:0]}) else $error("low");
	a_chan_high: assert property (rd_ok && avs_address_in == 4'hb |=> avs_readdata_out == {30'h0, tx_channel_index_out[9:8]}) else $error("high");
	cover property (step_reserved_out);
	cover property (gain_sel_out);
	cover property (amp_target_invalid_out);
endmodule // txch_monitor
bind tx_channel_scan_gain_regs txch_monitor mon (.*);
